// [src/tsc_port.sv]
// target side serial configuration port of the sensor tag
`timescale 1ns/100ps
`include "tsc_map.svh"
// Summary of operation
// - port takes clock edges only while enable high
// - input bit sampled on falling clock edge
// - output line changes on rising clock edge
// - output high while busy, host checks low
// - command and data shifted in MSB first
// - output high marks response ready for clocking
// - output high while memory write runs
// - pending write finishes after enable falls
// - everything grouped in whole bytes
// - top two command bits select type
// - write address 11 bits, then incrementing
// - write address wraps within 16-byte page
// - reads stream incrementing bytes until enable falls
// - direct op has index and argument fields
module tsc_port #(
	parameter int unsigned WAKE_CYC = (`TSC_WAKE_NS * `TSC_CLK_MHZ + 999) / 1000
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic SCLK,
	input wire logic DIN,
	output logic DOUT,
	output logic DOUT_OE,
	output logic WAKE_REQ,
	output logic [`TSC_ADDR_W-1:0] MEM_ADDR,
	output tsc_pkg::tsc_byte_t MEM_WDATA,
	output logic MEM_WE,
	output logic MEM_RE,
	input wire tsc_pkg::tsc_byte_t MEM_RDATA,
	input wire logic MEM_RVALID,
	input wire logic MEM_BUSY,
	output logic RST_TRIG,
	input wire logic CAL_BUSY,
	output tsc_pkg::tsc_iomode_e IO_MODE,
	output logic [1:0] CTRL_MODE,
	output logic CTRL_MODE_STB
);
	import tsc_pkg::*;

	localparam logic [`TSC_WAKE_W-1:0] WAKE_LONG = `TSC_WAKE_W'(WAKE_CYC);
	localparam logic [`TSC_WAKE_W-1:0] WAKE_SHORT =
		`TSC_WAKE_W'((`TSC_WAKE_LOCK_NS * `TSC_CLK_MHZ + 999) / 1000);

	logic ce_m_q, ce_s_q, sclk_m_q, sclk_s_q, sclk_p_q, din_m_q, din_s_q;
	logic rise, fall, io_lock;
	tsc_state_e state_q;
	logic [`TSC_WAKE_W-1:0] wake_q;
	logic [2:0] bit_q;
	logic [1:0] nbyte_q;
	tsc_byte_t in_q, cmd_hi_q, out_q;
	logic id_q;
	logic [`TSC_ADDR_W-1:0] addr_q;
	tsc_byte_t page_q [`TSC_PAGE_BYTES];
	logic [`TSC_PAGE_BYTES-1:0] mask_q;
	logic [`TSC_PAGE_LSB-1:0] widx_q, cidx_q;
	logic dout_d, rd_next;
	tsc_byte_t in_byte;

	// pins come from the host's domain, two flops before any use
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ce_m_q <= 1'b0;
			ce_s_q <= 1'b0;
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_p_q <= 1'b0;
			din_m_q <= 1'b0;
			din_s_q <= 1'b0;
		end else begin
			ce_m_q <= CE;
			ce_s_q <= ce_m_q;
			sclk_m_q <= SCLK;
			sclk_s_q <= sclk_m_q;
			sclk_p_q <= sclk_s_q;
			din_m_q <= DIN;
			din_s_q <= din_m_q;
		end
	end

	// edges only count while enabled
	assign rise = ce_s_q & sclk_s_q & ~sclk_p_q;
	assign fall = ce_s_q & ~sclk_s_q & sclk_p_q;
	assign io_lock = (IO_MODE == TSC_IO_SPI);
	assign in_byte = {in_q[6:0], din_s_q};
	assign rd_next = (state_q == TSC_RD_OUT) & rise & (bit_q == 3'h7);

	// main sequencer
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= TSC_IDLE;
			wake_q <= '0;
			bit_q <= 3'h0;
			nbyte_q <= 2'h0;
			in_q <= 8'h00;
			cmd_hi_q <= 8'h00;
			id_q <= 1'b0;
		end else begin
			case (state_q)
				TSC_IDLE: begin
					bit_q <= 3'h0;
					nbyte_q <= 2'h0;
					wake_q <= '0;
					if (ce_s_q) begin
						state_q <= TSC_WAKE;
					end
				end
				TSC_WAKE: begin
					// short wake when fast clock was kept alive
					wake_q <= wake_q + 1'b1;
					if (!ce_s_q) begin
						state_q <= TSC_IDLE;
					end else if (wake_q >= (io_lock ? WAKE_SHORT : WAKE_LONG)) begin
						state_q <= TSC_CMD;
					end
				end
				TSC_CMD: begin
					if (!ce_s_q) begin
						state_q <= TSC_IDLE;
					end else if (fall) begin
						in_q <= in_byte;
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							nbyte_q <= nbyte_q + 2'h1;
							cmd_hi_q <= in_byte;
							if (nbyte_q == 2'h0) begin
								if (in_byte[7:6] == `TSC_TYPE_DIRECT) begin
									if (in_byte[5:3] == `TSC_DOP_RESET) begin
										state_q <= TSC_DIR_BUSY;
									end else if (in_byte[5:3] == `TSC_DOP_HWID) begin
										id_q <= 1'b1;
										state_q <= TSC_RD_FETCH;
									end else begin
										state_q <= TSC_DONE;
									end
								end else if (in_byte[7:6] != `TSC_TYPE_WRITE &&
									in_byte[7:6] != `TSC_TYPE_READ) begin
									state_q <= TSC_DONE;
								end
							end else if (cmd_hi_q[7:6] == `TSC_TYPE_READ) begin
								id_q <= 1'b0;
								state_q <= TSC_RD_FETCH;
							end else begin
								state_q <= TSC_WR_DATA;
							end
						end
					end
				end
				TSC_RD_FETCH: begin
					if (!ce_s_q) begin
						state_q <= TSC_IDLE;
					end else if (id_q || MEM_RVALID) begin
						state_q <= TSC_RD_OUT;
					end
				end
				TSC_RD_OUT: begin
					if (!ce_s_q) begin
						state_q <= TSC_IDLE;
					end else if (rise) begin
						bit_q <= bit_q + 3'h1;
					end
				end
				TSC_WR_DATA: begin
					if (!ce_s_q) begin
						// the write starts only when enable drops
						state_q <= (mask_q != '0) ? TSC_WR_COMMIT : TSC_IDLE;
					end else if (fall) begin
						in_q <= in_byte;
						bit_q <= bit_q + 3'h1;
					end
				end
				TSC_WR_COMMIT: begin
					if (cidx_q == {`TSC_PAGE_LSB{1'b1}} && !MEM_WE &&
						(!mask_q[cidx_q] || !MEM_BUSY)) begin
						state_q <= TSC_WR_WAIT;
					end
				end
				TSC_WR_WAIT: begin
					if (!MEM_BUSY && !MEM_WE) begin
						state_q <= TSC_IDLE;
					end
				end
				TSC_DIR_BUSY: begin
					if (!CAL_BUSY && !RST_TRIG) begin
						state_q <= TSC_DONE;
					end
				end
				TSC_DONE: begin
					if (!ce_s_q) begin
						state_q <= TSC_IDLE;
					end
				end
				default: begin
					state_q <= TSC_IDLE;
				end
			endcase
		end
	end

	// write page buffer; offset wraps inside the page
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			mask_q <= '0;
			widx_q <= '0;
			cidx_q <= '0;
		end else if (state_q == TSC_CMD) begin
			mask_q <= '0;
			widx_q <= in_byte[`TSC_PAGE_LSB-1:0];
			cidx_q <= '0;
		end else if (state_q == TSC_WR_DATA && fall && bit_q == 3'h7) begin
			page_q[widx_q] <= in_byte;
			mask_q[widx_q] <= 1'b1;
			widx_q <= widx_q + 1'b1;
		end else if (state_q == TSC_WR_COMMIT && (MEM_WE || !mask_q[cidx_q])) begin
			// step on after the strobe, or at once past an unwritten byte, so the address stands with its byte
			if (cidx_q != {`TSC_PAGE_LSB{1'b1}}) begin
				cidx_q <= cidx_q + 1'b1;
			end
		end
	end

	// memory port: address, strobes and data
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			addr_q <= '0;
			MEM_WE <= 1'b0;
			MEM_RE <= 1'b0;
			MEM_WDATA <= 8'h00;
		end else begin
			MEM_WE <= 1'b0;
			MEM_RE <= 1'b0;
			if (state_q == TSC_CMD && fall && bit_q == 3'h7 && nbyte_q == 2'h1) begin
				addr_q <= {cmd_hi_q[2:0], in_byte};
				MEM_RE <= (cmd_hi_q[7:6] == `TSC_TYPE_READ);
			end else if (rd_next && !id_q) begin
				addr_q <= addr_q + 1'b1;
				MEM_RE <= 1'b1;
			end else if (state_q == TSC_WR_COMMIT && !MEM_WE && !MEM_BUSY &&
				mask_q[cidx_q]) begin
				MEM_WE <= 1'b1;
				MEM_WDATA <= page_q[cidx_q];
			end
		end
	end
	assign MEM_ADDR = (state_q == TSC_WR_COMMIT || state_q == TSC_WR_WAIT) ?
		{addr_q[`TSC_ADDR_W-1:`TSC_PAGE_LSB], cidx_q} : addr_q;

	// response shifter, reloaded after each eighth bit
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			out_q <= 8'h00;
		end else if (state_q == TSC_RD_FETCH && id_q) begin
			out_q <= `TSC_HW_ID;
		end else if (rd_next && id_q) begin
			out_q <= `TSC_HW_ID;
		end else if (MEM_RVALID && (state_q == TSC_RD_FETCH || state_q == TSC_RD_OUT)) begin
			out_q <= MEM_RDATA;
		end else if (state_q == TSC_RD_OUT && rise) begin
			out_q <= {out_q[6:0], 1'b0};
		end
	end

	// direct operations and their persistent settings
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			IO_MODE <= TSC_IO_APP;
			CTRL_MODE <= 2'h0;
			CTRL_MODE_STB <= 1'b0;
			RST_TRIG <= 1'b0;
		end else begin
			CTRL_MODE_STB <= 1'b0;
			RST_TRIG <= 1'b0;
			if (state_q == TSC_CMD && fall && bit_q == 3'h7 && nbyte_q == 2'h0 &&
				in_byte[7:6] == `TSC_TYPE_DIRECT) begin
				if (in_byte[5:3] == `TSC_DOP_RESET) begin
					RST_TRIG <= 1'b1;
					IO_MODE <= TSC_IO_APP; // master reset drops the lock
				end else if (in_byte[5:3] == `TSC_DOP_SETIO) begin
					if (in_byte[2:0] == `TSC_ARG_APP) begin
						IO_MODE <= TSC_IO_APP;
					end else if (in_byte[2:0] == `TSC_ARG_SPI) begin
						IO_MODE <= TSC_IO_SPI;
					end else if (in_byte[2:0] == `TSC_ARG_SCAN) begin
						IO_MODE <= TSC_IO_SCAN;
					end
				end else if (in_byte[5:3] == `TSC_DOP_SETMODE) begin
					CTRL_MODE <= in_byte[1:0];
					CTRL_MODE_STB <= 1'b1;
				end
			end
		end
	end

	// output line: busy high, ready high, then data on rising edges
	always_comb begin
		case (state_q)
			TSC_WAKE, TSC_WR_COMMIT, TSC_WR_WAIT, TSC_DIR_BUSY: dout_d = 1'b1;
			TSC_RD_OUT: dout_d = rise ? out_q[7] : DOUT;
			default: dout_d = 1'b0;
		endcase
	end

	// pin ownership and wake request, kept through a pending write
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			DOUT <= 1'b0;
			DOUT_OE <= 1'b0;
			WAKE_REQ <= 1'b0;
		end else begin
			DOUT <= (state_q == TSC_RD_FETCH || state_q == TSC_IDLE) ? 1'b0 : dout_d;
			// ready only on the fetch step, a zero last bit must not look like ready
			if (state_q == TSC_RD_FETCH && ce_s_q && (id_q || MEM_RVALID)) begin
				DOUT <= 1'b1;
			end
			DOUT_OE <= ce_s_q | io_lock | (state_q != TSC_IDLE);
			WAKE_REQ <= ce_s_q | io_lock | (state_q != TSC_IDLE);
		end
	end
endmodule : tsc_port

// [inc/tsc_map.svh]
// constants for the tag serial configuration port
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
`define TSC_CLK_MHZ 100
`define TSC_WAKE_NS 50000
`define TSC_WAKE_LOCK_NS 500
`define TSC_WAKE_W 16
`define TSC_ADDR_W 11
`define TSC_PAGE_BYTES 16
`define TSC_PAGE_LSB 4
`define TSC_TYPE_WRITE 2'h0
`define TSC_TYPE_READ 2'h1
`define TSC_TYPE_DIRECT 2'h3
`define TSC_DOP_RESET 3'h0
`define TSC_DOP_SETIO 3'h1
`define TSC_DOP_HWID 3'h2
`define TSC_DOP_SETMODE 3'h4
`define TSC_ARG_APP 3'h0
`define TSC_ARG_SPI 3'h1
`define TSC_ARG_SCAN 3'h2
// hardware id byte, value is arbitrary
`define TSC_HW_ID 8'h5A
`endif

// [inc/tsc_pkg.sv]
// types shared by the tag serial configuration port
package tsc_pkg;
	typedef enum logic [3:0] {
		TSC_IDLE = 4'b0000,
		TSC_WAKE = 4'b0001,
		TSC_CMD = 4'b0010,
		TSC_RD_FETCH = 4'b0011,
		TSC_RD_OUT = 4'b0100,
		TSC_WR_DATA = 4'b0101,
		TSC_WR_COMMIT = 4'b0110,
		TSC_WR_WAIT = 4'b0111,
		TSC_DIR_BUSY = 4'b1000,
		TSC_DONE = 4'b1001
	} tsc_state_e;
	typedef enum logic [1:0] {
		TSC_IO_APP = 2'b00,
		TSC_IO_SPI = 2'b01,
		TSC_IO_SCAN = 2'b10
	} tsc_iomode_e;
	typedef logic [7:0] tsc_byte_t;
endpackage : tsc_pkg

// [dv/tsc_props.sv]
// assertion checker bound to the serial configuration port
`timescale 1ns/100ps
module tsc_props (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic DOUT,
	input wire logic DOUT_OE,
	input wire logic WAKE_REQ,
	input wire logic MEM_WE,
	input wire logic MEM_RE,
	input wire logic MEM_BUSY,
	input wire logic RST_TRIG,
	input wire logic CTRL_MODE_STB
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// strobes last one cycle, a stuck one would repeat memory accesses
	property p_we_once; MEM_WE |=> !MEM_WE; endproperty
	a_we_once: assert property (p_we_once) else $error("long write strobe");
	property p_re_once; MEM_RE |=> !MEM_RE; endproperty
	a_re_once: assert property (p_re_once) else $error("long read strobe");
	property p_rst_once; RST_TRIG |=> !RST_TRIG; endproperty
	a_rst_once: assert property (p_rst_once) else $error("long reset pulse");
	property p_stb_own; CTRL_MODE_STB |-> DOUT_OE; endproperty
	a_stb_own: assert property (p_stb_own) else $error("mode strobe while idle");
	// writes run only after enable has gone, with busy shown
	property p_wr_busy; MEM_WE |-> DOUT && WAKE_REQ; endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write without busy");
	property p_wr_late; MEM_WE |-> !$past(CE, 2); endproperty
	a_wr_late: assert property (p_wr_late) else $error("write while enabled");
	property p_hold_on; MEM_BUSY |-> WAKE_REQ; endproperty
	a_hold_on: assert property (p_hold_on) else $error("wake dropped early");
	// enable wakes the port and shows busy within the sync latency
	property p_ce_busy; $rose(CE) |-> ##[1:5] DOUT; endproperty
	a_ce_busy: assert property (p_ce_busy) else $error("no busy after enable");
	property p_ce_own; $rose(CE) |-> ##[1:5] (DOUT_OE && WAKE_REQ); endproperty
	a_ce_own: assert property (p_ce_own) else $error("no wake after enable");
	c_burst: cover property (MEM_WE ##[1:20] MEM_WE);
	c_reset: cover property (RST_TRIG);
	c_mode: cover property (CTRL_MODE_STB);
endmodule : tsc_props
bind tsc_port tsc_props u_props (.*);

// [dv/tsc_host.sv]
// host model driving the serial configuration link
`timescale 1ns/100ps
module tsc_host (
	input wire logic clk,
	input wire logic dout,
	output logic ce,
	output logic sclk,
	output logic din
);
	logic [7:0] rx;
	bit hung = 1'b0;
	// link starts low; ce and sclk return low after each frame, din keeps the inverse of its last bit
	initial begin
		ce = 1'b0;
		sclk = 1'b0;
		din = 1'b0;
	end
	// bounded wait for a level on the busy/ready line
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		repeat (6) @(negedge clk);
		while (dout !== v && n < 4000) begin
			@(negedge clk);
			n++;
		end
		hung |= (n == 4000);
	endtask : wait_lvl
	task automatic begin_cmd();
		ce = 1'b1;
		wait_lvl(1'b0);
	endtask : begin_cmd
	// released data line shows the inverse, not the last bit
	task automatic end_cmd();
		ce = 1'b0;
		din = ~din;
		repeat (8) @(negedge clk);
	endtask : end_cmd
	// 80 ns bit, din held across the fall, dout read before next rise
	task automatic xfer(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b1;
			din = tx[i];
			repeat (4) @(negedge clk);
			sclk = 1'b0;
			repeat (4) @(negedge clk);
			rx[i] = dout;
		end
	endtask : xfer
endmodule : tsc_host

// [dv/tb_top.sv]
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
`include "tsc_map.svh"
module tb_top;
	import tsc_pkg::*;
	logic CORE_CLK;
	logic RESETN;
	logic MEM_RVALID;
	logic MEM_BUSY;
	logic CAL_BUSY;
	tsc_byte_t MEM_RDATA;
	logic dout_last;
	wire dout_line;
	logic CE, SCLK, DIN, DOUT, DOUT_OE, WAKE_REQ, MEM_WE, MEM_RE, RST_TRIG, CTRL_MODE_STB;
	logic [10:0] MEM_ADDR;
	tsc_byte_t MEM_WDATA;
	tsc_iomode_e IO_MODE;
	logic [1:0] CTRL_MODE;
	tsc_byte_t mem [2048];
	tsc_byte_t exp_mem [2048];
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int rst_seen = 0;
	int stb_seen = 0;
	logic [31:0] rng = 32'h5980E265;
	tsc_port #(.WAKE_CYC(20)) u_dut (
		.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CE(CE), .SCLK(SCLK), .DIN(DIN),
		.DOUT(DOUT), .DOUT_OE(DOUT_OE), .WAKE_REQ(WAKE_REQ),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE),
		.MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID), .MEM_BUSY(MEM_BUSY),
		.RST_TRIG(RST_TRIG), .CAL_BUSY(CAL_BUSY), .IO_MODE(IO_MODE),
		.CTRL_MODE(CTRL_MODE), .CTRL_MODE_STB(CTRL_MODE_STB)
	);
	tsc_host u_host (.clk(CORE_CLK), .dout(dout_line), .ce(CE), .sclk(SCLK), .din(DIN));
	// released line shows the inverse of its last driven level, never a stale copy
	assign dout_line = DOUT_OE ? DOUT : ~dout_last;
	always @(posedge CORE_CLK) begin
		if (!RESETN)
			dout_last <= 1'b0;
		else if (DOUT_OE)
			dout_last <= DOUT;
	end
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd
	// byte i of a burst stays inside the start page
	function automatic logic [10:0] wa(input logic [10:0] a, input int i);
		return {a[10:4], a[3:0] + i[3:0]};
	endfunction : wa
	task automatic chk(input logic [10:0] got, input logic [10:0] want);
		compares++;
		if (got !== want) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, want);
		end
	endtask : chk
	task automatic summarize();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic dop(input logic [7:0] c);
		u_host.begin_cmd();
		u_host.xfer(c);
		u_host.end_cmd();
	endtask : dop
	// memory stand-in: busy drops at a varying cycle, calibration busy after reset
	always @(negedge CORE_CLK) begin
		MEM_RVALID <= MEM_RE;
		MEM_RDATA <= mem[MEM_ADDR];
		if (MEM_WE) begin
			mem[MEM_ADDR] <= MEM_WDATA;
			MEM_BUSY <= 1'b1;
		end else if (cyc[2:0] == 3'h0)
			MEM_BUSY <= 1'b0;
		CAL_BUSY <= RST_TRIG | (CAL_BUSY & cyc[3:0] != 4'h0);
		rst_seen += RST_TRIG;
		stb_seen += CTRL_MODE_STB;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		logic [10:0] a;
		int n;
		logic [7:0] d;
		RESETN = 1'b0;
		foreach (mem[k]) begin
			mem[k] = 8'(rnd());
			exp_mem[k] = mem[k];
		end
		repeat (10) @(negedge CORE_CLK);
		RESETN = 1'b1;
		// bursts, the first one running a full page past its start
		for (int t = 0; t < 3; t++) begin
			a = 11'(rnd());
			n = (t == 0) ? 17 : int'(rnd() % 32'd16) + 1;
			u_host.begin_cmd();
			u_host.xfer({5'h00, a[10:8]});
			u_host.xfer(a[7:0]);
			for (int i = 0; i < n; i++) begin
				d = 8'(rnd());
				exp_mem[wa(a, i)] = d;
				u_host.xfer(d);
			end
			u_host.end_cmd();
			u_host.wait_lvl(1'b0);
			for (int i = 0; i < 16; i++) chk(mem[wa(a, i)], exp_mem[wa(a, i)]);
			u_host.begin_cmd();
			u_host.xfer({5'h08, a[10:8]});
			u_host.xfer(a[7:0]);
			u_host.wait_lvl(1'b1);
			for (int i = 0; i < 3; i++) begin
				u_host.xfer(8'(rnd()));
				chk(u_host.rx, exp_mem[a + 11'(i)]);
			end
			u_host.end_cmd();
		end
		u_host.begin_cmd();
		u_host.xfer(8'hD5);
		u_host.wait_lvl(1'b1);
		u_host.xfer(8'h00);
		chk(u_host.rx, `TSC_HW_ID);
		u_host.end_cmd();
		// io modes end in serial lock, so later wakes take the short path
		for (int p = 2; p < 5; p++) begin
			dop(8'hC8 | 8'(p % 3));
			chk(IO_MODE, 11'(p % 3));
		end
		for (int m = 0; m < 4; m++) begin
			dop(8'hE0 | 8'(m));
			chk(CTRL_MODE, 11'(m));
		end
		// unknown type code is swallowed until enable drops
		dop(8'h9F);
		chk(CTRL_MODE, 11'(3));
		chk(stb_seen, 4);
		dop(8'hC0);
		repeat (40) @(negedge CORE_CLK);
		chk(rst_seen, 1);
		chk(IO_MODE, TSC_IO_APP);
		chk(WAKE_REQ, 0);
		chk(DOUT_OE, 0);
		chk(u_host.hung, 0);
		summarize();
	end
endmodule : tb_top
